// ### src/host_bus_dma_buffer_port.sv
// Host write path, DMA handshake and buffer RAM write sequencer
`timescale 1ns/1ps
`include "host_port_defines.svh"
module host_bus_dma_buffer_port #(
	parameter int ADDR_W = 16
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic hostSelect_n,
	input wire logic hostWrite_n,
	input wire logic [3:0] host_reg_index,
	input wire logic [15:0] host_data_bus,
	input wire logic dma_grant_n,
	input wire logic transfer_end_mark,
	input wire logic endMarkActiveHigh,
	input wire logic bufWantsData,
	input wire logic dmaRearm,
	input wire logic txActive,
	input wire logic rxLoopbackActive,
	output logic ready,
	output logic dma_request_line,
	output logic regWriteStrobe,
	output logic [3:0] regWriteIndex,
	output logic [15:0] regWriteData,
	output host_port_pkg::sramBus_s sramBus
);
	localparam logic [1:0] WAIT_LOAD = 2'(`WAIT_CYC - 1);
	localparam logic [1:0] PULSE_LAST = 2'(`WE_PULSE_CYC - 1);
	localparam logic [1:0] SPACING = 2'(`BACK_TO_BACK_CYC);

	logic writePrev;
	logic writeFall;
	logic accessSel;
	logic portAccess;
	logic endMarkSeen;
	logic endMarkNow;
	logic [1:0] waitCnt;
	logic [1:0] sinceLast;
	logic [1:0] pulseCnt;
	logic pending;
	logic [15:0] pendingData;
	logic [ADDR_W-1:0] bufAddr;
	host_port_pkg::ramState_e ramState;

	// Grant acts as chip select and forces the buffer port
	assign accessSel = !dma_grant_n || !hostSelect_n;
	assign portAccess = !dma_grant_n || (host_reg_index == `BUF_PORT_INDEX);
	assign writeFall = writePrev && !hostWrite_n && accessSel;
	// Polarity folded into one active-true level
	assign endMarkNow = (transfer_end_mark == endMarkActiveHigh);

	// Strobe edge detect on synchronous inputs
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			writePrev <= 1'b1;
		end else begin
			writePrev <= hostWrite_n;
		end
	end

	// Spacing since last port write, saturating
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sinceLast <= SPACING;
		end else if (writeFall && portAccess) begin
			sinceLast <= 2'h0;
		end else if (sinceLast != SPACING) begin
			sinceLast <= sinceLast + 2'h1;
		end
	end

	// Wait insertion only for fast port writes while loopback keeps both sides busy
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			waitCnt <= 2'h0;
		end else if (writeFall && portAccess && sinceLast < SPACING && txActive && rxLoopbackActive) begin
			waitCnt <= WAIT_LOAD;
		end else if (waitCnt != 2'h0) begin
			waitCnt <= waitCnt - 2'h1;
		end
	end

	// Ready dips for the decode cycle only, unless a wait is running
	assign ready = !writeFall && (waitCnt == 2'h0);

	// Register writes leave as a one-cycle strobe with held data
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			regWriteStrobe <= 1'b0;
			regWriteIndex <= 4'h0;
			regWriteData <= 16'h0000;
		end else begin
			regWriteStrobe <= writeFall && !portAccess;
			if (writeFall && !portAccess) begin
				regWriteIndex <= host_reg_index;
				regWriteData <= host_data_bus;
			end
		end
	end

	// End mark is remembered until software rearms the channel
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			endMarkSeen <= 1'b0;
		end else if (!dma_grant_n && endMarkNow) begin
			endMarkSeen <= 1'b1; // set wins over rearm
		end else if (dmaRearm) begin
			endMarkSeen <= 1'b0;
		end
	end

	// Request stops once the marked grant has gone away; the far side keeps its
	// strobes inside the grant, so a mark outside it is never looked for
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			dma_request_line <= 1'b0;
		end else begin
			dma_request_line <= bufWantsData && !(endMarkSeen && dma_grant_n);
		end
	end

	// One port word held until the RAM sequencer is free
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pending <= 1'b0;
			pendingData <= 16'h0000;
		end else if (writeFall && portAccess) begin
			pending <= 1'b1;
			pendingData <= host_data_bus;
		end else if (ramState == host_port_pkg::RAM_IDLE) begin
			pending <= 1'b0;
		end
	end

	// Two-state write: select and enable fall together, rise together
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ramState <= host_port_pkg::RAM_IDLE;
			pulseCnt <= 2'h0;
		end else begin
			unique case (ramState)
				host_port_pkg::RAM_IDLE: begin
					pulseCnt <= 2'h0;
					if (pending) begin
						ramState <= host_port_pkg::RAM_PULSE;
					end
				end
				host_port_pkg::RAM_PULSE: begin
					pulseCnt <= pulseCnt + 2'h1;
					if (pulseCnt == PULSE_LAST) begin
						ramState <= host_port_pkg::RAM_IDLE;
					end
				end
			endcase
		end
	end

	// Address advances after each finished write so it holds past select release
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			bufAddr <= ADDR_W'(`BUF_ADDR_RESET);
		end else if (ramState == host_port_pkg::RAM_PULSE && pulseCnt == PULSE_LAST) begin
			bufAddr <= bufAddr + ADDR_W'(1);
		end
	end

	// RAM pins from flops; enable never outside select
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sramBus <= '{addr: 16'h0000, data: 16'h0000, select_n: 1'b1, writeEn_n: 1'b1, dataOe: 1'b0};
		end else begin
			sramBus.addr <= 16'(bufAddr);
			if (ramState == host_port_pkg::RAM_IDLE && pending) begin
				sramBus.data <= pendingData;
				sramBus.select_n <= 1'b0;
				sramBus.writeEn_n <= 1'b0;
				sramBus.dataOe <= 1'b1;
			end else if (ramState == host_port_pkg::RAM_PULSE && pulseCnt == PULSE_LAST) begin
				sramBus.select_n <= 1'b1;
				sramBus.writeEn_n <= 1'b1;
				sramBus.dataOe <= 1'b0;
			end
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_enableFall;
		$fell(sramBus.writeEn_n);
	endsequence
	sequence s_pulseHeld;
		!sramBus.writeEn_n [*2];
	endsequence

	property p_readyFast;
		writeFall && !(portAccess && txActive && rxLoopbackActive) |-> !ready ##1 ready;
	endproperty
	a_readyFast: assert property (p_readyFast) else $error("ready not back after one cycle");

	property p_waitLength;
		writeFall && portAccess && sinceLast < SPACING && txActive && rxLoopbackActive
			|-> !ready [*3] ##1 ready;
	endproperty
	a_waitLength: assert property (p_waitLength) else $error("wait not three cycles");

	property p_noRequestAfterMark;
		endMarkSeen && dma_grant_n && !dmaRearm |=> !dma_request_line;
	endproperty
	a_noRequestAfterMark: assert property (p_noRequestAfterMark) else $error("request after end mark");

	property p_grantIsPort;
		!dma_grant_n && writeFall |=> !regWriteStrobe;
	endproperty
	a_grantIsPort: assert property (p_grantIsPort) else $error("grant write went to a register");

	property p_markPolarity;
		!dma_grant_n && (transfer_end_mark == endMarkActiveHigh) |=> endMarkSeen;
	endproperty
	a_markPolarity: assert property (p_markPolarity) else $error("end mark missed");

	property p_enableInsideSelect;
		!sramBus.writeEn_n |-> !sramBus.select_n;
	endproperty
	a_enableInsideSelect: assert property (p_enableInsideSelect) else $error("enable outside select");

	property p_pulseWidth;
		s_enableFall |-> s_pulseHeld ##1 sramBus.writeEn_n;
	endproperty
	a_pulseWidth: assert property (p_pulseWidth) else $error("enable pulse not two cycles");

	property p_sequence;
		ramState == host_port_pkg::RAM_IDLE && pending |=> !sramBus.select_n ##2 sramBus.select_n;
	endproperty
	a_sequence: assert property (p_sequence) else $error("RAM write not 100 ns");
endmodule : host_bus_dma_buffer_port

// ### src/host_port_defines.svh
// Constants for the host bus, DMA and buffer RAM write port
// Notes on behaviour
// - Plain writes drop ready only one cycle
// - Fast port writes in loopback insert wait
// - End mark stops requests after grant ends
// - Grant selects buffer port, index ignored
// - End mark polarity is programmable
// - Write enable nested inside select, 100 ns (60 ns min)
`ifndef HOST_PORT_DEFINES_SVH
`define HOST_PORT_DEFINES_SVH
`define CLK_PERIOD_NS 50
`define BACK_TO_BACK_NS 100
`define WAIT_MAX_NS 175
`define WE_PULSE_MIN_NS 60
// Spacing up to which writes count as back to back (rounded down)
`define BACK_TO_BACK_CYC (`BACK_TO_BACK_NS / `CLK_PERIOD_NS)
// Longest wait rounds down
`define WAIT_CYC (`WAIT_MAX_NS / `CLK_PERIOD_NS)
// Least pulse rounds up
`define WE_PULSE_CYC ((`WE_PULSE_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BUF_PORT_INDEX 4'h8
`define BUF_ADDR_RESET 16'h0000
`endif

// ### src/host_port_pkg.sv
// Types shared by the host bus port
package host_port_pkg;
	typedef struct packed {
		logic [15:0] addr;
		logic [15:0] data;
		logic select_n;
		logic writeEn_n;
		logic dataOe;
	} sramBus_s;
	typedef enum logic [1:0] {
		RAM_IDLE = 2'b01,
		RAM_PULSE = 2'b10
	} ramState_e;
endpackage : host_port_pkg

// ### verification/host_master_model.sv
// Host processor and DMA controller model issuing write cycles
`timescale 1ns/1ps
module host_master_model (
	input wire logic clk,
	input wire logic go,
	input wire logic useGrant,
	input wire logic markOn,
	input wire logic markHigh,
	input wire logic [3:0] idx,
	input wire logic [15:0] wdata,
	output logic select_n = 1'b1,
	output logic write_n = 1'b1,
	output logic grant_n = 1'b1,
	output logic mark = 1'b1,
	output logic [3:0] index = 4'h0,
	output logic [15:0] data = 16'h0000
);
	logic [1:0] phase = 2'h0;
	// Strobe low one cycle, then the bus is held one more cycle and released
	always @(posedge clk) begin
		if (go && write_n) begin
			select_n <= useGrant;
			grant_n <= !useGrant;
			write_n <= 1'b0;
			mark <= markOn ~^ markHigh; // Mark starts with the grant
			index <= idx;
			data <= wdata;
			phase <= 2'h1;
		end else if (phase == 2'h1) begin
			write_n <= 1'b1;
			mark <= !markHigh; // Mark ends a cycle before the grant
			phase <= 2'h2;
		end else if (phase == 2'h2) begin
			select_n <= 1'b1;
			grant_n <= 1'b1;
			index <= ~index; // Released lines must not keep the last value
			data <= ~data;
			phase <= 2'h0;
		end else begin
			mark <= !markHigh;
		end
	end
endmodule : host_master_model

// ### verification/host_bus_dma_buffer_port_bench.sv
// Self-checking bench for the host port, DMA handshake and RAM writes
`timescale 1ns/1ps
module host_bus_dma_buffer_port_bench;
	logic clk = 1'b0, rst_n = 1'b0, go = 1'b0, useGrant = 1'b0, markOn = 1'b0;
	logic markHigh = 1'b0, rearm = 1'b0, loopback = 1'b0, loopRx = 1'b0, wants = 1'b1, ended = 1'b0;
	logic [3:0] idx = 4'h0;
	logic [15:0] wdata = 16'h0000, expAddr = 16'h0000;
	logic [31:0] lfsr = 32'h00007E4E;
	logic selN, wrN, grantN, mark, ready, req, strobe;
	logic [3:0] pIdx, rIdx;
	logic [15:0] pData, rData;
	host_port_pkg::sramBus_s ram;
	int n_mismatch = 0, checks_done = 0, cycles = 0;
	host_master_model i_host (.clk(clk), .go(go), .useGrant(useGrant), .markOn(markOn), .markHigh(markHigh),
		.idx(idx), .wdata(wdata), .select_n(selN), .write_n(wrN), .grant_n(grantN), .mark(mark), .index(pIdx),
		.data(pData));
	host_bus_dma_buffer_port i_dut (.clk(clk), .rst_n(rst_n), .hostSelect_n(selN), .hostWrite_n(wrN),
		.host_reg_index(pIdx), .host_data_bus(pData), .dma_grant_n(grantN), .transfer_end_mark(mark),
		.endMarkActiveHigh(markHigh), .bufWantsData(wants), .dmaRearm(rearm), .txActive(loopback),
		.rxLoopbackActive(loopRx), .ready(ready), .dma_request_line(req), .regWriteStrobe(strobe),
		.regWriteIndex(rIdx), .regWriteData(rData), .sramBus(ram));
	always #25 clk = ~clk;
	// Cut a hang short; the sequence needs a few hundred cycles
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			n_mismatch++;
			give_verdict();
		end
	end
	function automatic logic [31:0] nextRand(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : nextRand
	task automatic checkBit(input logic got, input logic exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : checkBit
	task automatic checkWord(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : checkWord
	task automatic give_verdict();
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : give_verdict
	// One write through the model, checked cycle by cycle
	task automatic doWrite(input logic g, input logic m, input logic [3:0] i, input logic [15:0] d);
		logic port;
		port = g | (i == 4'h8);
		@(posedge clk);
		{useGrant, markOn, idx, wdata, go} <= {g, m, i, d, 1'b1};
		@(posedge clk) go <= 1'b0;
		@(negedge clk) checkBit(ready, 1'b0);
		@(negedge clk) checkBit(ready, 1'b1);
		checkBit(strobe, !port);
		if (!port) checkWord({12'h000, rIdx}, {12'h000, i});
		// RAM cycle starts one edge after the word is parked; strobe lasts one cycle
		@(negedge clk) checkBit(strobe, 1'b0);
		checkWord(port ? ram.data : rData, d);
		checkBit(ram.writeEn_n, !port);
		checkBit(ram.dataOe, port);
		if (port) checkWord(ram.addr, expAddr);
		@(negedge clk) checkBit(ram.writeEn_n | ram.select_n, !port);
		@(negedge clk) checkBit(ram.writeEn_n & ram.select_n, 1'b1);
		// Address pins trail the select release by one edge
		@(negedge clk) expAddr = expAddr + {15'h0000, port};
		ended = ended | m;
		checkWord(ram.addr, expAddr);
		checkBit(req, !ended);
	endtask : doWrite
	// Two port writes two cycles apart; wait only with both sides busy in loopback
	task automatic burst(input logic tx, input logic rx);
		@(posedge clk);
		{loopback, loopRx, useGrant, markOn, idx, go} <= {tx, rx, 1'b0, 1'b0, 4'h8, 1'b1};
		repeat (3) @(posedge clk);
		go <= 1'b0;
		@(negedge clk) checkBit(ready, 1'b0);
		@(negedge clk) checkBit(ready, !(tx & rx));
		@(negedge clk) checkBit(ready, !(tx & rx));
		@(negedge clk) checkBit(ready, 1'b1);
	endtask : burst
	// Reset, corner writes, random writes, end mark in both polarities, bursts
	initial begin
		repeat (16) @(posedge clk);
		@(negedge clk) checkBit(ready & ram.select_n & !req, 1'b1);
		@(posedge clk) rst_n <= 1'b1;
		doWrite(1'b0, 1'b0, 4'hF, 16'hFFFF);
		doWrite(1'b0, 1'b0, 4'h8, 16'hA5A5);
		doWrite(1'b1, 1'b0, 4'h3, 16'h5A5A);
		repeat (12) begin
			lfsr = nextRand(lfsr);
			doWrite(lfsr[20], 1'b0, lfsr[3:0], lfsr[31:16]);
		end
		// No buffer demand means no request
		@(posedge clk) wants <= 1'b0;
		repeat (2) @(posedge clk);
		@(negedge clk) checkBit(req, 1'b0);
		@(posedge clk) wants <= 1'b1;
		for (int pol = 0; pol < 2; pol++) begin
			@(posedge clk) {markHigh, rearm} <= {pol[0], 1'b1};
			@(posedge clk) rearm <= 1'b0;
			ended = 1'b0;
			doWrite(1'b1, 1'b0, 4'h2, 16'h1234);
			doWrite(1'b1, 1'b1, 4'h8, 16'h4321);
			doWrite(1'b1, 1'b0, 4'h1, 16'h0F0F);
		end
		burst(1'b0, 1'b0);
		burst(1'b1, 1'b0);
		burst(1'b0, 1'b1);
		burst(1'b1, 1'b1);
		give_verdict();
	end
endmodule : host_bus_dma_buffer_port_bench
